// *** common/csp_params.svh ***
// Constants for the caption slicer port: offsets, field positions, counts.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

`define CSP_ADDR_W        4
`define CSP_DATA_W        8
`define CSP_OFF_MODE      4'h0
`define CSP_OFF_RX_LOW    4'h1
`define CSP_OFF_RX_HIGH   4'h2
`define CSP_OFF_STATUS    4'h3
`define CSP_OFF_IRQ_STAT  4'h4
`define CSP_OFF_IRQ_MASK  4'h5

`define CSP_MODE_RESET    8'h00
`define CSP_BYTE_ZERO     8'h00

`define CSP_DLY_NONE      2'h0
`define CSP_DLY_TAPS      6
`define CSP_FILT_INT3     2'h1
`define CSP_FILT_INT2     2'h3
`define CSP_CNT3_MAX      3'h7
`define CSP_CNT2_MAX      3'h3
`define CSP_CNT_ZERO      3'h0

`define CSP_WORD_BITS     16
`define CSP_BIT_CNT_W     4
`define CSP_LOW_LAST      4'h7
`define CSP_HIGH_LAST     4'hf
`define CSP_SYNC_N        3
`define CSP_SYNC_CLK      0
`define CSP_SYNC_DATA     1
`define CSP_SYNC_VS       2

`define CSP_EV_START      0
`define CSP_EV_DONE       1
`define CSP_EV_VSFALL     2

`endif

// *** common/csp_pkg.sv ***
// Types shared by the caption slicer port modules.
package csp_pkg;

	typedef struct packed {
		logic [3:0] rsvd;
		logic [1:0] data_filter_select;
		logic [1:0] clock_delay_select;
	} csp_mode_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       word_done_flag;
		logic       start_seen_flag;
		logic       field_window_flag;
	} csp_status_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       vs_fall;
		logic       word_done;
		logic       start_seen;
	} csp_events_t;

	typedef enum logic [1:0] {
		CSP_RX_IDLE,
		CSP_RX_WAIT_START,
		CSP_RX_SHIFT,
		CSP_RX_DONE
	} csp_rx_state_t;

endpackage

// *** design/csp_clk_delay.sv ***
// Programmable delay of the synchronised slicer clock by 0, 2, 4 or 6 clock periods.
`timescale 1ns/10ps
`include "csp_params.svh"
module csp_clk_delay
	import csp_pkg::*;
(
	input  wire logic       ref_clk_i,   // Main clock.
	input  wire logic       rstn_i,      // Asynchronous reset, active low.
	input  wire logic       clk_sync_i,  // Synchronised slicer clock.
	input  wire logic [1:0] sel_i,       // Delay code.
	output logic            clk_dly_o    // Delayed slicer clock.
);

	logic [`CSP_DLY_TAPS-1:0] hist_r;
	logic [`CSP_DLY_TAPS:0]   chain;

	// Each tap takes the one before it; the input stands in front of the first.
	assign chain = {hist_r, clk_sync_i};

	genvar gi;
	generate
		for (gi = 0; gi < `CSP_DLY_TAPS; gi++) begin : g_tap
			always_ff @(posedge ref_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					hist_r[gi] <= 1'b0;
				end else begin
					hist_r[gi] <= chain[gi];
				end
			end
		end
	endgenerate

	// Code n takes the tap that is 2n cycles behind the input.
	always_comb begin
		unique case (sel_i)
			2'h0: clk_dly_o = clk_sync_i;
			2'h1: clk_dly_o = hist_r[1];
			2'h2: clk_dly_o = hist_r[3];
			2'h3: clk_dly_o = hist_r[5];
		endcase
	end

	AST_DLY_SIX: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(sel_i == 2'h3) && $past(sel_i, 6) == 2'h3 |-> clk_dly_o == $past(clk_sync_i, 6))
		else $error("clock delay of six periods wrong");

	AST_DLY_TWO: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(sel_i == 2'h1) && $past(sel_i, 2) == 2'h1 |-> clk_dly_o == $past(clk_sync_i, 2))
		else $error("clock delay of two periods wrong");

endmodule

// *** design/csp_integrator.sv ***
// Optional saturating up-down integration filter for the slicer data line.
`timescale 1ns/10ps
`include "csp_params.svh"
module csp_integrator
	import csp_pkg::*;
(
	input  wire logic       ref_clk_i,   // Main clock.
	input  wire logic       rstn_i,      // Asynchronous reset, active low.
	input  wire logic       data_i,      // Synchronised slicer data.
	input  wire logic [1:0] mode_i,      // Filter code.
	output logic            filt_o       // Filtered data.
);

	logic [2:0] cnt_r;
	logic [2:0] cnt_max;

	assign cnt_max = (mode_i == `CSP_FILT_INT3) ? `CSP_CNT3_MAX : `CSP_CNT2_MAX;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= `CSP_CNT_ZERO;
		end else if (cnt_r > cnt_max) begin
			cnt_r <= cnt_max;
		end else if (data_i && cnt_r < cnt_max) begin
			cnt_r <= cnt_r + 3'h1;
		end else if (!data_i && cnt_r != `CSP_CNT_ZERO) begin
			cnt_r <= cnt_r - 3'h1;
		end
	end

	always_comb begin
		unique case (mode_i)
			`CSP_FILT_INT3: filt_o = cnt_r[2];
			`CSP_FILT_INT2: filt_o = cnt_r[1];
			default:        filt_o = data_i;
		endcase
	end

	AST_INT_SAT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(mode_i == `CSP_FILT_INT2) && $past(mode_i) == `CSP_FILT_INT2 |-> cnt_r <= `CSP_CNT2_MAX)
		else $error("two-bit integrator left its range");

	AST_INT_NONE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!mode_i[0] |-> filt_o == data_i)
		else $error("filter passes wrong value without integration");

	AST_INT_UP: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		((mode_i == `CSP_FILT_INT3) && data_i)[*4] |=> filt_o)
		else $error("integrator output not high after four high samples");

endmodule

// *** design/csp_top.sv ***
// Caption slicer port: serial receiver, status flags, registers and interrupt.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "csp_params.svh"
module csp_top
	import csp_pkg::*;
(
	input  wire logic                   ref_clk_i,          // Main clock, 40 MHz.
	input  wire logic                   rstn_i,             // Asynchronous reset, active low.
	input  wire logic                   slicer_clock_in_i,  // Slicer clock pin, asynchronous.
	input  wire logic                   slicer_data_in_i,   // Slicer data pin, asynchronous.
	input  wire logic                   vertical_sync_i,    // Vertical sync, asynchronous.
	input  wire logic [`CSP_ADDR_W-1:0] reg_addr_i,         // Register address.
	input  wire logic [`CSP_DATA_W-1:0] reg_wdata_i,        // Register write data.
	input  wire logic                   reg_wr_i,           // Write strobe.
	input  wire logic                   reg_rd_i,           // Read strobe.
	output logic      [`CSP_DATA_W-1:0] reg_rdata_o,        // Read data, cycle after strobe.
	output logic                        irq_o               // Level interrupt.
);

	logic [`CSP_SYNC_N-1:0]   sync1_r;
	logic [`CSP_SYNC_N-1:0]   sync2_r;
	logic                     clk_dly;
	logic                     clk_prev_r;
	logic                     vs_prev_r;
	logic                     clk_rise;
	logic                     vs_fall;
	logic                     filt_bit;
	csp_mode_t                mode_r;
	csp_status_t              status_r;
	csp_events_t              irq_stat_r;
	csp_events_t              irq_mask_r;
	csp_events_t              events;
	csp_rx_state_t            state_r;
	logic                     field_phase_r;
	logic [`CSP_WORD_BITS-1:0] shift_r;
	logic [`CSP_WORD_BITS-1:0] shift_nxt;
	logic [`CSP_BIT_CNT_W-1:0] bit_cnt_r;
	logic [`CSP_DATA_W-1:0]   rx_low_r;
	logic [`CSP_DATA_W-1:0]   rx_high_r;
	logic [`CSP_DATA_W-1:0]   reg_rdata_r;
	logic                     irq_r;
	logic                     first_field;
	logic                     start_prev_r;
	logic                     done_prev_r;

	function automatic logic hit(input logic [`CSP_ADDR_W-1:0] a,
		input logic [`CSP_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Two flip-flops on every pin that comes from outside this clock.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {vertical_sync_i, slicer_data_in_i, slicer_clock_in_i};
			sync2_r <= sync1_r;
		end
	end

	csp_clk_delay u_clk_delay (
		.ref_clk_i  (ref_clk_i),
		.rstn_i     (rstn_i),
		.clk_sync_i (sync2_r[`CSP_SYNC_CLK]),
		.sel_i      (mode_r.clock_delay_select),
		.clk_dly_o  (clk_dly)
	);

	csp_integrator u_integrator (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.data_i    (sync2_r[`CSP_SYNC_DATA]),
		.mode_i    (mode_r.data_filter_select),
		.filt_o    (filt_bit)
	);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_prev_r <= 1'b0;
			vs_prev_r  <= 1'b0;
		end else begin
			clk_prev_r <= clk_dly;
			vs_prev_r  <= sync2_r[`CSP_SYNC_VS];
		end
	end

	assign clk_rise    = clk_dly && !clk_prev_r;
	assign vs_fall     = vs_prev_r && !sync2_r[`CSP_SYNC_VS];
	assign first_field = field_phase_r;
	assign shift_nxt   = {filt_bit, shift_r[`CSP_WORD_BITS-1:1]};

	// Fields alternate at each sync fall; the phase after the first fall after reset is first.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			field_phase_r <= 1'b0;
		end else if (vs_fall) begin
			field_phase_r <= !field_phase_r;
		end
	end

	// Receiver sequence; a sync fall restarts it for the first field, idles it for the second, and clears the flags.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r   <= CSP_RX_IDLE;
			bit_cnt_r <= '0;
			shift_r   <= '0;
		end else if (vs_fall) begin
			state_r   <= field_phase_r ? CSP_RX_IDLE : CSP_RX_WAIT_START;
			bit_cnt_r <= '0;
		end else if (clk_rise) begin
			unique case (state_r)
				CSP_RX_IDLE: begin
					state_r <= CSP_RX_IDLE;
				end
				CSP_RX_WAIT_START: begin
					if (filt_bit) begin
						state_r   <= CSP_RX_SHIFT;
						bit_cnt_r <= '0;
					end
				end
				CSP_RX_SHIFT: begin
					shift_r   <= shift_nxt;
					bit_cnt_r <= bit_cnt_r + 4'h1;
					if (bit_cnt_r == `CSP_HIGH_LAST) begin
						state_r <= CSP_RX_DONE;
					end
				end
				CSP_RX_DONE: begin
					state_r <= CSP_RX_DONE;
				end
			endcase
		end
	end

	// Byte registers load as each half of the word completes.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_low_r  <= `CSP_BYTE_ZERO;
			rx_high_r <= `CSP_BYTE_ZERO;
		end else if (clk_rise && !vs_fall && state_r == CSP_RX_SHIFT) begin
			if (bit_cnt_r == `CSP_LOW_LAST) begin
				rx_low_r <= shift_nxt[`CSP_WORD_BITS-1:`CSP_DATA_W];
			end
			if (bit_cnt_r == `CSP_HIGH_LAST) begin
				rx_high_r <= shift_nxt[`CSP_WORD_BITS-1:`CSP_DATA_W];
			end
		end
	end

	// Status flags live only within the first field.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			status_r <= '0;
		end else if (vs_fall) begin
			status_r <= '0;
		end else if (clk_rise && first_field) begin
			status_r.field_window_flag <= 1'b1;
			if (state_r == CSP_RX_WAIT_START && filt_bit) begin
				status_r.start_seen_flag <= 1'b1;
			end
			if (state_r == CSP_RX_SHIFT && bit_cnt_r == `CSP_HIGH_LAST) begin
				status_r.word_done_flag <= 1'b1;
			end
		end
	end

	// Last cycle's flags, so that each rise of a flag counts as one event.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_prev_r <= 1'b0;
			done_prev_r  <= 1'b0;
		end else begin
			start_prev_r <= status_r.start_seen_flag;
			done_prev_r  <= status_r.word_done_flag;
		end
	end

	always_comb begin
		events            = '0;
		events.start_seen = status_r.start_seen_flag && !start_prev_r;
		events.word_done  = status_r.word_done_flag && !done_prev_r;
		events.vs_fall    = vs_fall;
	end

	// Mode and mask registers; status bits clear on a written one, a new event wins.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r     <= `CSP_MODE_RESET;
			irq_mask_r <= '0;
		end else if (reg_wr_i) begin
			if (hit(reg_addr_i, `CSP_OFF_MODE)) begin
				mode_r <= reg_wdata_i;
			end
			if (hit(reg_addr_i, `CSP_OFF_IRQ_MASK)) begin
				irq_mask_r <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_r <= '0;
		end else if (reg_wr_i && hit(reg_addr_i, `CSP_OFF_IRQ_STAT)) begin
			irq_stat_r <= (irq_stat_r & ~reg_wdata_i) | events;
		end else begin
			irq_stat_r <= irq_stat_r | events;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |((irq_stat_r | events) & irq_mask_r);
		end
	end

	// Read data stand for exactly one cycle; write-only and unmapped read as zero.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_r <= `CSP_BYTE_ZERO;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`CSP_OFF_RX_LOW:   reg_rdata_r <= rx_low_r;
				`CSP_OFF_RX_HIGH:  reg_rdata_r <= rx_high_r;
				`CSP_OFF_STATUS:   reg_rdata_r <= status_r;
				`CSP_OFF_IRQ_STAT: reg_rdata_r <= irq_stat_r;
				`CSP_OFF_IRQ_MASK: reg_rdata_r <= irq_mask_r;
				default:           reg_rdata_r <= `CSP_BYTE_ZERO;
			endcase
		end else begin
			reg_rdata_r <= `CSP_BYTE_ZERO;
		end
	end

	assign reg_rdata_o = reg_rdata_r;
	assign irq_o       = irq_r;

	AST_FLAGS_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		vs_fall |=> status_r == '0)
		else $error("flags not cleared by sync fall");

	AST_FIELD_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		clk_rise && first_field && !vs_fall |=> status_r.field_window_flag)
		else $error("field flag not set by first clock rise");

	AST_NO_SECOND: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!first_field && !$past(first_field) |-> status_r == '0)
		else $error("flag set outside the first field");

	AST_START_ORDER: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		status_r.start_seen_flag |-> status_r.field_window_flag)
		else $error("start flag without field flag");

	AST_DONE_ORDER: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(status_r.word_done_flag) |-> status_r.start_seen_flag && state_r == CSP_RX_DONE)
		else $error("done flag without a complete word");

	AST_DONE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(status_r.word_done_flag)
		|-> rx_high_r == $past(shift_nxt[`CSP_WORD_BITS-1:`CSP_DATA_W]))
		else $error("high byte not loaded with done flag");

	AST_SHIFT_IN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		clk_rise && !vs_fall && state_r == CSP_RX_SHIFT |=> shift_r[15] == $past(filt_bit))
		else $error("sampled bit not shifted in");

	AST_RD_DATA: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		reg_rd_i && reg_addr_i == `CSP_OFF_RX_LOW |=> reg_rdata_o == $past(rx_low_r))
		else $error("low byte read wrong");

	AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		|(irq_stat_r & irq_mask_r) |=> irq_o)
		else $error("interrupt not raised");

	AST_IRQ_LOW: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		((irq_stat_r | events) & irq_mask_r) == '0 |=> !irq_o)
		else $error("interrupt raised with nothing pending");

	AST_RD_IDLE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!reg_rd_i |=> reg_rdata_o == `CSP_BYTE_ZERO)
		else $error("read data present without a read");

	AST_EV_START: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(status_r.start_seen_flag) |=> irq_stat_r.start_seen)
		else $error("start event not recorded");

	AST_EV_SYNC: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		vs_fall |=> irq_stat_r.vs_fall)
		else $error("sync fall event not recorded");

	AST_LOW_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		clk_rise && !vs_fall && state_r == CSP_RX_SHIFT && bit_cnt_r == `CSP_LOW_LAST
		|=> rx_low_r == $past(shift_nxt[`CSP_WORD_BITS-1:`CSP_DATA_W]))
		else $error("low byte not loaded after eight bits");

endmodule

// *** tb/csp_slicer_model.sv ***
// Data slicer model: slicer clock, serial data and vertical sync.
`timescale 1ns/10ps
module csp_slicer_model (
	output logic slk_o,  // Slicer clock, low between frames.
	output logic sdat_o, // Serial data.
	output logic vs_o    // Vertical sync, idle high.
);
	int skew = -100;

	initial begin
		slk_o = 1'b0;
		sdat_o = 1'b0;
		vs_o = 1'b1;
	end

	task automatic vs_fall();
		vs_o = 1'b0;
		#400 vs_o = 1'b1;
		#400;
	endtask

	// Bits go LSB first, 200 ns each; data moves skew ns away from the clock rise.
	task automatic send(input logic [31:0] b, input int n, input bit last);
		for (int i = 0; i < n; i++) begin
			if (skew < 0) begin
				#(100 + skew) sdat_o = b[i];
				#(-skew) slk_o = 1'b1;
				#100;
			end else begin
				#100 slk_o = 1'b1;
				#(skew) sdat_o = b[i];
				#(100 - skew);
			end
			slk_o = 1'b0;
		end
		// A released data line shows the inverse of its last bit once the bit's hold is over.
		if (last) begin
			#(100 + skew);
			sdat_o = ~sdat_o;
		end
	endtask
endmodule

// *** tb/csp_tb.sv ***
// Self-checking bench for the caption slicer port.
`timescale 1ns/10ps
`include "csp_params.svh"
module testbench;
	import csp_pkg::*;
	logic        clk;
	logic        rstn;
	logic        slk;
	logic        sdat;
	logic        vs;
	logic [3:0]  addr;
	logic [7:0]  wdat;
	logic [7:0]  rdat;
	logic        wr;
	logic        rd;
	logic        irq;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          skews [7] = '{-100, -50, 0, 50, -75, -75, 0};
	logic [7:0]  modes [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h0e, 8'h0a};
	logic [15:0] words [7] = '{16'ha5c3, 16'h5a3c, 16'h0ff0, 16'h8001, 16'h1234,
		16'hedcb, 16'hc96e};

	csp_slicer_model i_slicer (.slk_o(slk), .sdat_o(sdat), .vs_o(vs));

	csp_top i_dut (
		.ref_clk_i(clk), .rstn_i(rstn), .slicer_clock_in_i(slk),
		.slicer_data_in_i(sdat), .vertical_sync_i(vs), .reg_addr_i(addr),
		.reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
		.irq_o(irq)
	);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_bit(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check8(n, e, rdat);
	endtask

	// Leaves room for synchronisers, the longest delay and the filter.
	task automatic settle();
		repeat (12) @(posedge clk);
		#1;
	endtask

	task automatic run_cfg(input int c);
		logic [15:0] w;
		w = words[c];
		bus_wr(`CSP_OFF_MODE, modes[c]);
		rd_chk("mode", `CSP_OFF_MODE, 8'h00);
		bus_wr(`CSP_OFF_IRQ_STAT, 8'h07);
		bus_wr(`CSP_OFF_IRQ_MASK, 8'h00);
		i_slicer.skew = skews[c];
		i_slicer.vs_fall();
		rd_chk("status idle", `CSP_OFF_STATUS, 8'h00);
		i_slicer.send(32'h0, 2, 1'b0);
		settle();
		rd_chk("status field", `CSP_OFF_STATUS, 8'h01);
		i_slicer.send(32'h1, 1, 1'b0);
		settle();
		rd_chk("status start", `CSP_OFF_STATUS, 8'h03);
		i_slicer.send({24'h0, w[7:0]}, 8, 1'b0);
		settle();
		rd_chk("low byte", `CSP_OFF_RX_LOW, w[7:0]);
		@(posedge clk);
		#1 check8("read data after", 8'h00, rdat);
		rd_chk("status half", `CSP_OFF_STATUS, 8'h03);
		i_slicer.send({24'h0, w[15:8]}, 8, 1'b0);
		settle();
		rd_chk("high byte", `CSP_OFF_RX_HIGH, w[15:8]);
		rd_chk("status done", `CSP_OFF_STATUS, 8'h07);
		bus_wr(`CSP_OFF_RX_LOW, 8'hff);
		i_slicer.send({16'h0, ~w}, 16, 1'b1);
		settle();
		rd_chk("low byte kept", `CSP_OFF_RX_LOW, w[7:0]);
		rd_chk("irq status", `CSP_OFF_IRQ_STAT, 8'h07);
		check_bit("irq masked", 1'b0, irq);
		bus_wr(`CSP_OFF_IRQ_MASK, 8'h02);
		rd_chk("irq mask", `CSP_OFF_IRQ_MASK, 8'h02);
		settle();
		check_bit("irq raised", 1'b1, irq);
		bus_wr(`CSP_OFF_IRQ_STAT, 8'h02);
		settle();
		check_bit("irq cleared", 1'b0, irq);
		rd_chk("irq status left", `CSP_OFF_IRQ_STAT, 8'h05);
		i_slicer.vs_fall();
		rd_chk("status ended", `CSP_OFF_STATUS, 8'h00);
		i_slicer.send({15'h0, ~w, 1'b1}, 17, 1'b1);
		settle();
		rd_chk("status second field", `CSP_OFF_STATUS, 8'h00);
		rd_chk("high byte kept", `CSP_OFF_RX_HIGH, w[15:8]);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		rstn = 1'b0;
		addr = 4'h0;
		wdat = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 6; a++)
			rd_chk("reset value", 4'(a), 8'h00);
		rd_chk("unmapped", 4'h9, 8'h00);
		i_slicer.send(32'h000f_fffe, 24, 1'b1);
		settle();
		rd_chk("status no field", `CSP_OFF_STATUS, 8'h00);
		rd_chk("low byte no field", `CSP_OFF_RX_LOW, 8'h00);
		for (int c = 0; c < 7; c++)
			run_cfg(c);
		wrap_up();
	end
endmodule
